// ===== design/tres_pkg.sv
// Purpose: Shared constants and carrier types for the temperature result block
// Assumes: Single 100 MHz clock, byte-wide register access from an SMBus front end
// Notes:   Temperatures on the converter side are signed whole degrees plus quarters
package tres_pkg;

  // Register offsets
  localparam logic [7:0] TRES_OFS_LOCAL     = 8'h00;
  localparam logic [7:0] TRES_OFS_UPPER     = 8'h01;
  localparam logic [7:0] TRES_OFS_STATUS    = 8'h02;
  localparam logic [7:0] TRES_OFS_CFG_RD    = 8'h03;
  localparam logic [7:0] TRES_OFS_CFG_WR    = 8'h09;
  localparam logic [7:0] TRES_OFS_FRACTION  = 8'h10;
  localparam logic [7:0] TRES_OFS_LIM_FIRST = 8'h05;
  localparam logic [7:0] TRES_OFS_LIM_LAST  = 8'h08;
  localparam logic [7:0] TRES_OFS_LIM2_FIRST = 8'h11;
  localparam logic [7:0] TRES_OFS_LIM2_LAST  = 8'h14;
  localparam logic [7:0] TRES_OFS_HYST      = 8'h21;

  // Field positions and reset values
  localparam int         TRES_CFG_RANGE_BIT = 2;
  localparam int         TRES_FRAC_MSB      = 7;
  localparam int         TRES_FRAC_LSB      = 6;
  localparam logic [7:0] TRES_RST_RESULT    = 8'h00;
  localparam logic [7:0] TRES_RST_POINTER   = 8'h00;
  localparam logic [7:0] TRES_RST_CFG       = 8'h00;
  localparam logic [7:0] TRES_RST_LIMIT     = 8'h00;
  localparam logic [7:0] TRES_RST_HYST      = 8'h0a;
  localparam int         TRES_NUM_LIMITS    = 9;

  // Encoding limits
  localparam logic signed [9:0] TRES_OFFSET     = 10'sd64;
  localparam logic signed [9:0] TRES_BIN_MAX    = 10'sd127;
  localparam logic signed [9:0] TRES_EXT_MIN    = -10'sd64;
  localparam logic signed [9:0] TRES_EXT_MAX    = 10'sd191;

  // Converter result for one channel
  typedef struct packed {
    logic              valid;    // One-cycle pulse, end of conversion
    logic              remote;   // 1 = remote diode channel
    logic              fault;    // Diode behaved as a short
    logic signed [9:0] degrees;  // Signed whole degrees
    logic        [1:0] quarter;  // Quarter degree fraction
  } tres_sample_t;

  // Byte access from the bus front end
  typedef struct packed {
    logic       start;    // One-cycle pulse, new transaction begins
    logic       wr_valid; // One-cycle pulse, write byte present
    logic [7:0] wr_data;  // Write byte
    logic       rd_req;   // One-cycle pulse, read byte consumed
  } tres_bus_t;

endpackage

// ===== design/tres_encode.sv
// Purpose: Turns a signed reading into the register byte of the active format
// Assumes: Degrees within the signed 10-bit range
// Notes:   Pure combinational, used for both channels
`timescale 1ns/1ns
module tres_encode (
  // Reading
  input  wire logic signed [9:0] degrees,
  input  wire logic              extended,
  // Encoded byte
  output logic             [7:0] code
);
  import tres_pkg::*;

  logic signed [9:0] shifted; // Offset applied value

  // Clamp then encode
  always_comb begin
    shifted = 10'sd0;
    if (extended) begin
      if (degrees < TRES_EXT_MIN) begin
        shifted = 10'sd0;
      end else if (degrees > TRES_EXT_MAX) begin
        shifted = TRES_EXT_MAX + TRES_OFFSET;
      end else begin
        shifted = degrees + TRES_OFFSET;
      end
    end else begin
      if (degrees < 10'sd0) begin
        shifted = 10'sd0;
      end else if (degrees > TRES_BIN_MAX) begin
        shifted = TRES_BIN_MAX;
      end else begin
        shifted = degrees;
      end
    end
    code = shifted[7:0];
  end

endmodule

// ===== design/tres_pointer.sv
// Purpose: Holds the register pointer and routes write bytes
// Assumes: First write byte of each transaction is the register address
// Notes:   Pointer has no address of its own
`timescale 1ns/1ns
module tres_pointer (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Bus bytes
  input  wire tres_pkg::tres_bus_t bus,
  // Pointer and data write strobe
  output logic             [7:0] pointer,
  output logic                   data_we,
  output logic             [7:0] data_byte
);
  import tres_pkg::*;

  typedef struct packed {
    logic [7:0] ptr;       // Selected register
    logic       have_addr; // Address byte taken this transaction
    logic       we;        // Data write pulse
    logic [7:0] wbyte;     // Data byte
  } tres_ptr_state_t;

  tres_ptr_state_t st;
  tres_ptr_state_t next_st;

  // First byte loads pointer, later bytes write data
  always_comb begin
    next_st    = st;
    next_st.we = 1'b0;
    if (bus.start) begin
      next_st.have_addr = 1'b0;
    end
    if (bus.wr_valid) begin
      if (!st.have_addr || bus.start) begin
        next_st.ptr       = bus.wr_data;
        next_st.have_addr = 1'b1;
      end else begin
        next_st.we    = 1'b1;
        next_st.wbyte = bus.wr_data;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '{ptr: TRES_RST_POINTER, have_addr: 1'b0, we: 1'b0, wbyte: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign pointer   = st.ptr;
  assign data_we   = st.we;
  assign data_byte = st.wbyte;

endmodule

// ===== design/tres_regs.sv
// Purpose: Temperature result registers with host register access
// Assumes: Converter delivers one-cycle sample pulses; bus front end gives bytes
// Notes:   Remote upper byte locks after a fraction read until read itself
//
// Notes on behaviour
// - Local result at 0x00, whole degrees
// - Remote result upper 0x01, fraction 0x10
// - Fraction in top two bits, quarters
// - Fraction read locks upper until read
// - Config bit 2 selects extended range
// - Range change applies from next conversion
// - Shorted remote diode keeps last good result
// - Binary default, offset binary extended
// - Binary range clamps to 0 and 127
// - First result of a conversion started after change uses new format
// - Limits unchanged when format switches
// - Fourteen byte-wide registers
// - First write byte loads pointer
// - Next byte writes pointed register; reads follow
// - Pointer resets to zero
// - Results converter-written, read-only, reset zero
`timescale 1ns/1ns
module tres_regs #(
  parameter int NUM_LIMITS = tres_pkg::TRES_NUM_LIMITS
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Converter side
  input  wire tres_pkg::tres_sample_t sample,
  input  wire logic                   conv_start,
  input  wire logic                   busy,
  input  wire logic             [6:0] status_flags,
  // Bus side
  input  wire tres_pkg::tres_bus_t    bus,
  output logic                  [7:0] rd_data,
  // Configuration to the rest of the device
  output logic                  [7:0] config_out,
  output logic                        extended_active
);
  import tres_pkg::*;

  typedef struct packed {
    logic [7:0] local_r;     // Local result byte
    logic [7:0] upper;       // Remote integer byte
    logic [1:0] frac;        // Remote quarter bits
    logic       locked;      // Upper byte frozen
    logic [7:0] held_upper;  // Upper value from fraction's measurement
    logic [7:0] cfg;         // Configuration byte
    logic       ext_conv;    // Range latched at conversion start
    logic [NUM_LIMITS*8-1:0] limits; // Limit bytes
    logic [7:0] rdata;       // Read byte
  } tres_state_t;

  tres_state_t st;
  tres_state_t next_st;

  logic [7:0] pointer;    // Register pointer
  logic       data_we;    // Data byte write pulse
  logic [7:0] data_byte;  // Data byte
  logic [7:0] code;       // Encoded sample

  // Pointer and write routing
  tres_pointer tres_pointer_inst (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .bus       (bus),
    .pointer   (pointer),
    .data_we   (data_we),
    .data_byte (data_byte)
  );

  // Encoding in the format latched for this conversion
  tres_encode tres_encode_inst (
    .degrees  (sample.degrees),
    .extended (st.ext_conv),
    .code     (code)
  );

  // Maps a limit offset to its slot, or NUM_LIMITS when not a limit
  function automatic int limit_slot(input logic [7:0] ofs);
    int slot;
    slot = NUM_LIMITS;
    if (ofs >= TRES_OFS_LIM_FIRST && ofs <= TRES_OFS_LIM_LAST) begin
      slot = int'(ofs - TRES_OFS_LIM_FIRST);
    end else if (ofs >= TRES_OFS_LIM2_FIRST && ofs <= TRES_OFS_LIM2_LAST) begin
      slot = int'(ofs - TRES_OFS_LIM2_FIRST) + 4;
    end else if (ofs == TRES_OFS_HYST) begin
      slot = 8;
    end
    return slot;
  endfunction

  // Read byte for the pointed register
  function automatic logic [7:0] read_byte(input tres_state_t s, input logic [7:0] ofs,
                                           input logic bsy, input logic [6:0] fl);
    logic [7:0] v;
    int         slot;
    v    = 8'h00;
    slot = limit_slot(ofs);
    case (ofs)
      TRES_OFS_LOCAL:    v = s.local_r;
      TRES_OFS_UPPER:    v = s.locked ? s.held_upper : s.upper;
      TRES_OFS_FRACTION: v = {s.frac, 6'b00_0000};
      TRES_OFS_STATUS:   v = {bsy, fl};
      TRES_OFS_CFG_RD:   v = s.cfg;
      default: begin
        if (slot < NUM_LIMITS) begin
          v = s.limits[slot*8 +: 8];
        end
      end
    endcase
    return v;
  endfunction

  // Result update, lock, configuration and limit writes
  always_comb begin
    int slot;
    slot    = limit_slot(pointer);
    next_st = st;
    // Range takes effect only when a conversion begins
    if (conv_start) begin
      next_st.ext_conv = st.cfg[TRES_CFG_RANGE_BIT];
    end
    // Converter writes results; host cannot
    if (sample.valid) begin
      if (!sample.remote) begin
        next_st.local_r = code;
      end else if (!sample.fault) begin
        next_st.frac = sample.quarter;
        if (!st.locked) begin
          next_st.upper = code;
        end
      end
    end
    // Host writes configuration and limits only
    if (data_we) begin
      if (pointer == TRES_OFS_CFG_WR) begin
        next_st.cfg = data_byte;
      end else if (slot < NUM_LIMITS) begin
        next_st.limits[slot*8 +: 8] = data_byte;
      end
    end
    // Read handling and coherency lock
    if (bus.rd_req) begin
      if (pointer == TRES_OFS_FRACTION) begin
        next_st.locked     = 1'b1;
        next_st.held_upper = (sample.valid && sample.remote && !sample.fault && !st.locked)
                             ? code : st.upper;
        if (st.locked) begin
          next_st.held_upper = st.held_upper;
        end
      end else if (pointer == TRES_OFS_UPPER) begin
        next_st.locked = 1'b0;
        if (st.locked) begin
          next_st.upper = st.held_upper;
        end
      end
    end
    next_st.rdata = read_byte(next_st, pointer, busy, status_flags);
  end

  // State register with power-on values
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st.local_r    <= TRES_RST_RESULT;
      st.upper      <= TRES_RST_RESULT;
      st.frac       <= 2'b00;
      st.locked     <= 1'b0;
      st.held_upper <= TRES_RST_RESULT;
      st.cfg        <= TRES_RST_CFG;
      st.ext_conv   <= 1'b0;
      st.limits     <= {(NUM_LIMITS*8){1'b0}};
      st.rdata      <= TRES_RST_RESULT;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data         = st.rdata;
  assign config_out      = st.cfg;
  assign extended_active = st.ext_conv;

endmodule

// ===== testbench/tres_regs_sva.sv
// Purpose: Port checker for tres_regs
// Assumes: Bus bytes come as start, address, then data
// Notes:   Pointer is shadowed from the bus bytes
`timescale 1ns/1ns
module tres_regs_sva #(
  parameter int NUM_LIMITS = 9
) (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  // Converter side
  input wire tres_pkg::tres_sample_t sample,
  input wire logic                   conv_start,
  input wire logic                   busy,
  input wire logic             [6:0] status_flags,
  // Bus side
  input wire tres_pkg::tres_bus_t    bus,
  input wire logic             [7:0] rd_data,
  input wire logic             [7:0] config_out,
  input wire logic                   extended_active
);
  import tres_pkg::*;
  logic [7:0] ptr;  // Shadow pointer
  logic       pend; // Address byte due
  logic       dwr;  // Data byte now
  assign dwr = bus.wr_valid && !(bus.start || pend);
  // Address byte loads the shadow pointer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr  <= 8'h00;
      pend <= 1'b1;
    end else if (bus.wr_valid && !dwr) begin
      ptr  <= bus.wr_data;
      pend <= 1'b0;
    end else if (bus.start) begin
      pend <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_rng;
    conv_start |=> extended_active == $past(config_out[TRES_CFG_RANGE_BIT]);
  endproperty
  a_rng: assert property (p_rng) else $error("range not latched");
  property p_hold;
    !conv_start |=> $stable(extended_active);
  endproperty
  a_hold: assert property (p_hold) else $error("range moved mid conversion");
  property p_cfgw;
    dwr && ptr == TRES_OFS_CFG_WR |-> ##2 config_out == $past(bus.wr_data, 2);
  endproperty
  a_cfgw: assert property (p_cfgw) else $error("config write lost");
  property p_cfgc;
    $changed(config_out) |-> $past(dwr && ptr == TRES_OFS_CFG_WR, 2);
  endproperty
  a_cfgc: assert property (p_cfgc) else $error("config changed unasked");
  property p_cfgr;
    ptr == TRES_OFS_CFG_RD && $past(ptr) == TRES_OFS_CFG_RD |-> rd_data == $past(config_out);
  endproperty
  a_cfgr: assert property (p_cfgr) else $error("config readback wrong");
  property p_stat;
    ptr == TRES_OFS_STATUS && $past(ptr) == TRES_OFS_STATUS
      |-> rd_data == {$past(busy), $past(status_flags)};
  endproperty
  a_stat: assert property (p_stat) else $error("status readback wrong");
  property p_frac;
    ptr == TRES_OFS_FRACTION && $past(ptr) == TRES_OFS_FRACTION |-> rd_data[5:0] == 6'h00;
  endproperty
  a_frac: assert property (p_frac) else $error("fraction low bits set");
  property p_clamp;
    (sample.valid && !sample.remote && !extended_active && sample.degrees > 10'sd127
      ##1 (ptr == TRES_OFS_LOCAL && !sample.valid) [*3]) |-> rd_data == 8'h7f;
  endproperty
  a_clamp: assert property (p_clamp) else $error("local clamp wrong");
endmodule
bind tres_regs tres_regs_sva #(.NUM_LIMITS(NUM_LIMITS)) tres_regs_sva_inst (
  .clk_sys(clk_sys), .rstn(rstn), .sample(sample), .conv_start(conv_start),
  .busy(busy), .status_flags(status_flags), .bus(bus), .rd_data(rd_data),
  .config_out(config_out), .extended_active(extended_active));

// ===== testbench/tres_host.sv
// Purpose: Bus host model for tres_regs
// Assumes: Byte pulses change just after a rising edge
// Notes:   Released data byte shows the inverse of the last one
`timescale 1ns/1ns
module tres_host (
  // Clock
  input  wire logic                clk_sys,
  // Bus
  output tres_pkg::tres_bus_t      bus,
  input  wire logic          [7:0] rd_data
);
  import tres_pkg::*;
  initial bus = '0;
  // Address byte, then an optional data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic has_d);
    @(posedge clk_sys);
    bus <= '{1'b1, 1'b1, a, 1'b0};
    @(posedge clk_sys);
    bus <= '{1'b0, has_d, d, 1'b0};
    @(posedge clk_sys);
    bus <= '{1'b0, 1'b0, ~d, 1'b0};
    repeat (3) @(posedge clk_sys);
  endtask
  // Point, take the byte, then mark it consumed
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wr(a, 8'h00, 1'b0);
    #1 q = rd_data;
    @(posedge clk_sys);
    bus.rd_req <= 1'b1;
    @(posedge clk_sys);
    bus.rd_req <= 1'b0;
  endtask
endmodule

// ===== testbench/tres_regs_bench.sv
// Purpose: Self-checking bench for tres_regs
// Assumes: Samples spaced several cycles apart
// Notes:   Expected bytes worked out by hand
`timescale 1ns/1ns
module tres_regs_bench;
  import tres_pkg::*;
  logic         clk_sys, rstn, conv_start, busy, extended_active;
  tres_sample_t sample;
  tres_bus_t    bus;
  logic   [6:0] status_flags;
  logic   [7:0] rd_data, config_out, q;
  int           err_count, total_checks;
  tres_regs #(.NUM_LIMITS(9)) tres_regs_inst (
    .clk_sys(clk_sys), .rstn(rstn), .sample(sample), .conv_start(conv_start),
    .busy(busy), .status_flags(status_flags), .bus(bus), .rd_data(rd_data),
    .config_out(config_out), .extended_active(extended_active));
  tres_host tres_host_inst (.clk_sys(clk_sys), .bus(bus), .rd_data(rd_data));
  // Free running clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    tres_host_inst.rd(a, q);
    chk(n, e, q);
  endtask
  // One converter result pulse
  task automatic smp(input logic r, input logic f, input logic signed [9:0] d,
                     input logic [1:0] qt);
    @(posedge clk_sys);
    sample <= '{1'b1, r, f, d, qt};
    @(posedge clk_sys);
    sample <= '{1'b0, ~r, ~f, ~d, ~qt};
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_reset();
    smp(1'b0, 1'b0, 10'sd25, 2'h0);
    chk("read_before_ptr", 8'h19, rd_data);
    rchk("frac_rst", TRES_OFS_FRACTION, 8'h00);
    rchk("upper_rst", TRES_OFS_UPPER, 8'h00);
    busy <= 1'b1;
    status_flags <= 7'h2a;
    rchk("status", TRES_OFS_STATUS, 8'haa);
    $display("t_reset done");
  endtask
  task automatic t_local();
    rchk("local_pre", TRES_OFS_LOCAL, 8'h19);
    smp(1'b0, 1'b0, 10'sd200, 2'h0);
    rchk("local_hi", TRES_OFS_LOCAL, 8'h7f);
    smp(1'b0, 1'b0, -10'sd5, 2'h0);
    rchk("local_lo", TRES_OFS_LOCAL, 8'h00);
    smp(1'b0, 1'b0, 10'sd75, 2'h0);
    tres_host_inst.wr(TRES_OFS_LOCAL, 8'h55, 1'b1);
    rchk("local_ro", TRES_OFS_LOCAL, 8'h4b);
    $display("t_local done");
  endtask
  task automatic t_range();
    tres_host_inst.wr(TRES_OFS_LIM_FIRST, 8'h0a, 1'b1);
    tres_host_inst.wr(TRES_OFS_CFG_WR, 8'h04, 1'b1);
    rchk("cfg", TRES_OFS_CFG_RD, 8'h04);
    chk("cfg_out", 8'h04, config_out);
    smp(1'b0, 1'b0, -10'sd55, 2'h0);
    rchk("old_fmt", TRES_OFS_LOCAL, 8'h00);
    @(posedge clk_sys);
    conv_start <= 1'b1;
    @(posedge clk_sys);
    conv_start <= 1'b0;
    smp(1'b0, 1'b0, 10'sd0, 2'h0);
    rchk("ofs_zero", TRES_OFS_LOCAL, 8'h40);
    chk("ext_active", 8'h01, {7'h00, extended_active});
    smp(1'b0, 1'b0, -10'sd55, 2'h0);
    rchk("ofs_neg", TRES_OFS_LOCAL, 8'h09);
    rchk("limit_kept", TRES_OFS_LIM_FIRST, 8'h0a);
    $display("t_range done");
  endtask
  task automatic t_remote();
    smp(1'b1, 1'b0, 10'sd25, 2'h2);
    rchk("frac_half", TRES_OFS_FRACTION, 8'h80);
    smp(1'b1, 1'b0, 10'sd30, 2'h3);
    rchk("upper_lock", TRES_OFS_UPPER, 8'h59);
    rchk("frac_3q", TRES_OFS_FRACTION, 8'hc0);
    rchk("upper_rel", TRES_OFS_UPPER, 8'h59);
    smp(1'b1, 1'b0, 10'sd40, 2'h0);
    rchk("upper", TRES_OFS_UPPER, 8'h68);
    smp(1'b1, 1'b1, 10'sd99, 2'h0);
    rchk("short", TRES_OFS_UPPER, 8'h68);
    $display("t_remote done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rstn = 1'b0;
    sample = '0;
    conv_start = 1'b0;
    busy = 1'b0;
    status_flags = 7'h00;
    err_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_local();
    t_range();
    t_remote();
    print_verdict();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end
endmodule
